// >>> hdl/stpdec_pkg.sv
package stpdec_pkg;

  // Register byte offsets.
  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_SW_RES  = 4'h4;
  localparam logic [3:0] REG_SW_CUR  = 4'h8;
  localparam logic [3:0] REG_STATUS  = 4'hC;

  // Control register fields.
  localparam int CTRL_SOFT_BIT  = 0;
  localparam int CTRL_CWCCW_BIT = 1;
  localparam int CTRL_FALL_BIT  = 2;
  localparam int CTRL_ALLOW_BIT = 3;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // Resolution in steps per revolution, current in tenths of an amp.
  localparam logic [16:0] RES_MAX     = 17'h1_9000;
  localparam logic [16:0] RES_MIN     = 17'h0_00C8;
  localparam logic [16:0] RES_RESET   = 17'h0_00C8;
  localparam logic [6:0]  CUR_MIN     = 7'h05;
  localparam logic [6:0]  CUR_MAX     = 7'h46;
  localparam logic [6:0]  CUR_RESET   = 7'h1A;
  localparam logic [16:0] FULL_STEPS  = 17'h0_00C8;

  // Reduced current share in percent.
  localparam logic [13:0] IDLE_PCT    = 14'h003C;
  localparam logic [13:0] PCT_DIV     = 14'h0064;

  // Idle interval and direction setup times.
  localparam int CLK_MHZ       = 100;
  localparam int IDLE_MS       = 1000;
  localparam int IDLE_CYCLES   = IDLE_MS * 1000 * CLK_MHZ;
  localparam int SETUP_US      = 5;
  localparam int SETUP_CYCLES  = SETUP_US * CLK_MHZ;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [16:0] steps_rev;
    logic [6:0]  run_cur;
    logic [6:0]  hold_cur;
    logic [6:0]  out_cur;
  } stpdec_set_type;

  typedef struct packed {
    logic step;
    logic dir;
    logic allow;
  } stpdec_ctl_type;

endpackage

// >>> hdl/stpdec_table.sv
`timescale 1ns/1ps
module stpdec_table
  import stpdec_pkg::*;
(
  input  wire logic [3:0]  res_sw,
  input  wire logic [2:0]  cur_sw,
  output logic      [16:0] sw_steps,
  output logic             sw_res_dflt,
  output logic      [6:0]  sw_cur,
  output logic             sw_cur_dflt
);

  // Switch ON reads as 0 on res pins and as 1 on cur pins, as wired.
  wire [2:0]  res_idx  = res_sw[2:0];
  wire        res_fine = res_sw[3];
  wire [7:0]  micro    = res_fine ? pick_fine(res_idx) : pick_bin(res_idx);

  function automatic logic [7:0] pick_bin(input logic [2:0] i);
    pick_bin = 8'h01 << i;
  endfunction

  function automatic logic [7:0] pick_fine(input logic [2:0] i);
    case (i)
      3'd0:    pick_fine = 8'h05;
      3'd1:    pick_fine = 8'h0A;
      3'd2:    pick_fine = 8'h14;
      3'd3:    pick_fine = 8'h19;
      3'd4:    pick_fine = 8'h28;
      3'd5:    pick_fine = 8'h32;
      3'd6:    pick_fine = 8'h64;
      default: pick_fine = 8'h7D;
    endcase
  endfunction

  function automatic logic [6:0] pick_cur(input logic [2:0] i);
    case (i)
      3'd1:    pick_cur = 7'h1A;
      3'd2:    pick_cur = 7'h22;
      3'd3:    pick_cur = 7'h28;
      3'd4:    pick_cur = 7'h30;
      3'd5:    pick_cur = 7'h36;
      3'd6:    pick_cur = 7'h3D;
      3'd7:    pick_cur = 7'h46;
      default: pick_cur = CUR_RESET;
    endcase
  endfunction

  assign sw_res_dflt = (res_sw == 4'h0);
  assign sw_steps    = 17'(micro * FULL_STEPS);
  assign sw_cur      = pick_cur(cur_sw);
  assign sw_cur_dflt = (cur_sw == 3'b000);

endmodule // stpdec_table

// >>> hdl/stpdec_top.sv
`timescale 1ns/1ps
module stpdec_top
  import stpdec_pkg::*;
#(
  parameter int IDLE_COUNT = IDLE_CYCLES
)
(
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        res_b0,
  input  wire logic        res_b1,
  input  wire logic        res_b2,
  input  wire logic        res_b3,
  input  wire logic        cur_b0,
  input  wire logic        cur_b1,
  input  wire logic        cur_b2,
  input  wire logic        idle_full,
  input  wire logic        step_pulse,
  input  wire logic        rotation_sense,
  input  wire logic        drive_allow,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output stpdec_pkg::stpdec_set_type setting,
  output logic             step_event,
  output logic             step_dir,
  output logic             drive_on,
  output logic             idle_reduced
);
  import stpdec_pkg::*;

  localparam int CW = $clog2(IDLE_COUNT + 1);

  // Two-stage synchronisers for all pin inputs except rst_b.
  logic [10:0] pin_s1;
  logic [10:0] pin_s2;
  wire  [10:0] pins = {idle_full, step_pulse, rotation_sense, drive_allow,
                       cur_b2, cur_b1, cur_b0, res_b3, res_b2, res_b1, res_b0};

  always_ff @(posedge clock)
  begin
    pin_s1 <= pins;
    pin_s2 <= pin_s1;
  end

  wire [3:0] res_sync   = pin_s2[3:0];
  wire [2:0] cur_sync   = pin_s2[6:4];
  wire       allow_sync = pin_s2[7];
  wire       dir_sync   = pin_s2[8];
  wire       step_sync  = pin_s2[9];
  wire       full_sync  = pin_s2[10];

  // Software registers.
  logic [31:0] ctrl;
  logic [16:0] soft_res;
  logic [6:0]  soft_cur;

  // AXI4-Lite write channel: address and data may arrive in either order.
  logic        aw_held;
  logic        w_held;
  logic [31:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  wire aw_fire  = s_axi_awvalid && s_axi_awready;
  wire w_fire   = s_axi_wvalid && s_axi_wready;
  wire wr_go    = aw_held && w_held && !s_axi_bvalid;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;

  // A register answers only at its exact word address, so aliases are refused.
  function automatic logic hit(input logic [31:0] addr, input logic [3:0] reg_off);
    hit = (addr == {28'h000_0000, reg_off});
  endfunction

  wire wr_ctrl = wr_go && hit(aw_addr, REG_CTRL);
  wire wr_res  = wr_go && hit(aw_addr, REG_SW_RES);
  wire wr_cur  = wr_go && hit(aw_addr, REG_SW_CUR);
  wire wr_ok   = wr_ctrl || wr_res || wr_cur;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++)
      merge[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
  endfunction

  wire [31:0] res_word  = merge({15'h0000, soft_res}, w_data, w_strb);
  wire [31:0] cur_word  = merge({25'h000_0000, soft_cur}, w_data, w_strb);
  wire [16:0] res_clip  = (res_word[31:17] != 15'h0000 || res_word[16:0] > RES_MAX) ? RES_MAX :
                          (res_word[16:0] < RES_MIN) ? RES_MIN : res_word[16:0];
  wire [6:0]  cur_clip  = (cur_word[31:7] != 25'h000_0000 || cur_word[6:0] > CUR_MAX) ? CUR_MAX :
                          (cur_word[6:0] < CUR_MIN) ? CUR_MIN : cur_word[6:0];

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 32'h0000_0000;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else
    begin
      if (aw_fire)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_fire)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      ctrl     <= CTRL_RESET;
      soft_res <= RES_RESET;
      soft_cur <= CUR_RESET;
    end
    else
    begin
      if (wr_ctrl)
        ctrl <= merge(ctrl, w_data, w_strb) & 32'h0000_000F;
      if (wr_res)
        soft_res <= res_clip;
      if (wr_cur)
        soft_cur <= cur_clip;
    end
  end

  // Read channel.
  wire        rd_go   = s_axi_arvalid && s_axi_arready;
  wire [31:0] rd_addr = s_axi_araddr;
  wire [31:0] status_word;
  wire [31:0] rd_word = hit(rd_addr, REG_CTRL)   ? ctrl :
                        hit(rd_addr, REG_SW_RES) ? {15'h0000, soft_res} :
                        hit(rd_addr, REG_SW_CUR) ? {25'h000_0000, soft_cur} :
                        hit(rd_addr, REG_STATUS) ? status_word : 32'h0000_0000;
  wire        rd_ok   = hit(rd_addr, REG_CTRL) || hit(rd_addr, REG_SW_RES) ||
                        hit(rd_addr, REG_SW_CUR) || hit(rd_addr, REG_STATUS);

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (rd_go)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Switch decoding.
  wire [16:0] sw_steps;
  wire        sw_res_dflt;
  wire [6:0]  sw_cur;
  wire        sw_cur_dflt;

  stpdec_table u_table (
    .res_sw      (res_sync),
    .cur_sw      (cur_sync),
    .sw_steps    (sw_steps),
    .sw_res_dflt (sw_res_dflt),
    .sw_cur      (sw_cur),
    .sw_cur_dflt (sw_cur_dflt)
  );

  wire soft_mode = ctrl[CTRL_SOFT_BIT];
  wire [16:0] next_steps = (soft_mode || sw_res_dflt) ? soft_res : sw_steps;
  wire [6:0]  next_run   = (soft_mode || sw_cur_dflt) ? soft_cur : sw_cur;
  wire [6:0]  half_cur   = {1'b0, next_run[6:1]};
  wire [6:0]  next_hold  = full_sync ? next_run : half_cur;
  wire [13:0] pct_prod   = 14'(next_run * IDLE_PCT);
  wire [6:0]  reduced    = 7'(pct_prod / PCT_DIV);

  // Step edge detection; in pulse/pulse mode either line is a step.
  logic step_q;
  logic dir_q;
  wire  cwccw     = ctrl[CTRL_CWCCW_BIT];
  wire  fall_edge = ctrl[CTRL_FALL_BIT];
  wire  step_edge = fall_edge ? (step_q && !step_sync) : (!step_q && step_sync);
  wire  ccw_edge  = fall_edge ? (dir_q && !dir_sync) : (!dir_q && dir_sync);
  wire  next_event = cwccw ? (step_edge || ccw_edge) : step_edge;
  wire  next_dir   = cwccw ? ccw_edge : dir_sync;

  // Idle counter.
  logic [CW-1:0] idle_cnt;
  wire  idle_done = (idle_cnt == CW'(IDLE_COUNT));

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      step_q   <= 1'b0;
      dir_q    <= 1'b0;
      idle_cnt <= '0;
    end
    else
    begin
      step_q <= step_sync;
      dir_q  <= dir_sync;
      if (next_event)
        idle_cnt <= '0;
      else if (!idle_done)
        idle_cnt <= idle_cnt + 1'b1;
    end
  end

  // Idle current: the lower of the standstill setting and the 60 percent cap.
  wire [6:0] idle_cur = (next_hold < reduced) ? next_hold : reduced;
  wire       next_on  = allow_sync ^ ctrl[CTRL_ALLOW_BIT];

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      setting      <= '{steps_rev: RES_RESET, run_cur: CUR_RESET, hold_cur: CUR_RESET, out_cur: CUR_RESET};
      step_event   <= 1'b0;
      step_dir     <= 1'b0;
      drive_on     <= 1'b0;
      idle_reduced <= 1'b0;
    end
    else
    begin
      setting.steps_rev <= next_steps;
      setting.run_cur   <= next_run;
      setting.hold_cur  <= next_hold;
      setting.out_cur   <= idle_done ? idle_cur : next_run;
      step_event        <= next_event && next_on;
      step_dir          <= next_dir;
      drive_on          <= next_on;
      idle_reduced      <= idle_done;
    end
  end

  assign status_word = {2'h0, idle_reduced, drive_on, step_dir, setting.out_cur,
                        sw_cur_dflt, sw_res_dflt, soft_mode, setting.steps_rev};

  property p_idle;
    @(posedge clock) disable iff (!rst_b) next_event |=> ##1 !idle_reduced;
  endproperty
  idle_restart_a: assert property (p_idle) else $error("idle flag not cleared by step");

  out_full_a: assert property (@(posedge clock) disable iff (!rst_b)
    !idle_reduced |-> setting.out_cur == setting.run_cur)
    else $error("running current wrong");

  out_reduced_a: assert property (@(posedge clock) disable iff (!rst_b)
    idle_reduced |-> setting.out_cur <= setting.run_cur)
    else $error("reduced current above run current");

  hold_half_a: assert property (@(posedge clock) disable iff (!rst_b)
    $stable(full_sync) && $stable(next_run) && !full_sync |=> setting.hold_cur == {1'b0, setting.run_cur[6:1]})
    else $error("standstill not half");

  soft_cur_a: assert property (@(posedge clock) disable iff (!rst_b)
    soft_mode |=> setting.run_cur == $past(soft_cur))
    else $error("software current not used");

  cur_range_a: assert property (@(posedge clock) disable iff (!rst_b)
    soft_cur >= CUR_MIN && soft_cur <= CUR_MAX)
    else $error("software current out of range");

  step_gate_a: assert property (@(posedge clock) disable iff (!rst_b)
    step_event |-> drive_on)
    else $error("step passed while drive off");

  sw_res_a: assert property (@(posedge clock) disable iff (!rst_b)
    !soft_mode && !sw_res_dflt |=> setting.steps_rev == $past(sw_steps))
    else $error("switch resolution not used");

endmodule // stpdec_top

// >>> verification/stpdec_motion_model.sv
`timescale 1ns/1ps
module stpdec_motion_model
  import stpdec_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       go,
  input  wire logic [7:0] n_steps,
  input  wire logic       dir_req,
  input  wire logic       ccw,
  output logic            step_pulse,
  output logic            rotation_sense,
  output logic            busy
);
  localparam int W = 250;

  initial
  begin
    step_pulse = 1'b0;
    rotation_sense = 1'b0;
    busy = 1'b0;
    forever
    begin
      @(posedge clock);
      if (go)
      begin
        busy <= 1'b1;
        if (!ccw)
          rotation_sense <= dir_req;
        // Direction settles well ahead of the first active edge.
        repeat (SETUP_CYCLES) @(posedge clock);
        repeat (n_steps)
        begin
          if (ccw && dir_req)
            rotation_sense <= 1'b1;
          else
            step_pulse <= 1'b1;
          repeat (W) @(posedge clock);
          step_pulse <= 1'b0;
          if (ccw)
            rotation_sense <= 1'b0;
          repeat (W) @(posedge clock);
        end
        busy <= 1'b0;
      end
    end
  end
endmodule // stpdec_motion_model

// >>> verification/testbench.sv
`timescale 1ns/1ps
module testbench;
  import stpdec_pkg::*;
  localparam int IDLE = 2000;
  logic clock = 1'b0, rst_b = 1'b0, drive_allow = 1'b1;
  logic res_b0 = 1'b0, res_b1 = 1'b0, res_b2 = 1'b0, res_b3 = 1'b0;
  logic cur_b0 = 1'b0, cur_b1 = 1'b0, cur_b2 = 1'b0, idle_full = 1'b0;
  logic step_pulse, rotation_sense, busy, go = 1'b0, dir_req = 1'b0, ccw = 1'b0;
  logic [7:0] n_steps = 8'h01;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, hv;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic step_event, step_dir, drive_on, idle_reduced, ev_dir;
  stpdec_set_type setting;
  int n_mismatch = 0, samples_checked = 0, cyc = 0, n_ev = 0, n_ev_hi = 0;
  int mult [8] = '{5, 10, 20, 25, 40, 50, 100, 125};
  logic [6:0] cur_tab [8] = '{CUR_RESET, 7'h1A, 7'h22, 7'h28, 7'h30, 7'h36, 7'h3D, 7'h46};
  logic [16:0] xs;

  stpdec_top #(.IDLE_COUNT(IDLE)) i_stpdec_top (.clock, .rst_b, .res_b0, .res_b1, .res_b2, .res_b3,
    .cur_b0, .cur_b1, .cur_b2, .idle_full, .step_pulse, .rotation_sense, .drive_allow, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .setting, .step_event, .step_dir, .drive_on, .idle_reduced);
  stpdec_motion_model i_stpdec_motion_model (.clock, .go, .n_steps, .dir_req, .ccw, .step_pulse,
    .rotation_sense, .busy);

  always #5 clock = ~clock;

  always @(posedge clock)
  begin
    cyc++;
    if (step_event === 1'b1)
    begin
      n_ev++;
      ev_dir = step_dir;
      if (step_pulse)
        n_ev_hi++;
    end
    if (cyc == 40000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end

  task print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input logic [71:0] g, e);
    samples_checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("FAIL t=%0t got %h expected %h", $time, g, e);
    end
  endtask

  task sw(input logic [3:0] r, input logic [2:0] c, input logic f);
    @(posedge clock);
    {res_b3, res_b2, res_b1, res_b0} <= r;
    {cur_b2, cur_b1, cur_b0} <= c;
    idle_full <= f;
    repeat (8) @(posedge clock);
  endtask

  // Handshakes are judged at the rising edge; each channel drops right after its own.
  task axi_wr(input logic [31:0] a, d);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    hv = 1'b0;
    while (!hv)
    begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
      hv = s_axi_bvalid;
      rsp = s_axi_bresp;
    end
    s_axi_bready <= 1'b0;
    repeat (4) @(posedge clock);
  endtask

  task axi_rd(input logic [31:0] a);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    hv = 1'b0;
    while (!hv)
    begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
      hv = s_axi_rvalid;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
    end
    s_axi_rready <= 1'b0;
  endtask

  task steps(input logic [7:0] n, input logic d, c);
    n_ev = 0;
    n_ev_hi = 0;
    ev_dir = ~d;
    @(posedge clock);
    n_steps <= n;
    dir_req <= d;
    ccw <= c;
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    @(posedge clock);
    while (busy)
      @(posedge clock);
    repeat (8) @(posedge clock);
  endtask

  initial
  begin
    repeat (20) @(posedge clock);
    chk(setting, {RES_RESET, CUR_RESET, CUR_RESET, CUR_RESET});
    chk(drive_on, 1'b0);
    rst_b <= 1'b1;
    $display("reset test done");
    for (int r = 0; r < 16; r++)
    begin
      sw(4'(r), 3'h3, 1'b1);
      xs = r[3] ? 17'(mult[r[2:0]] * FULL_STEPS) : (r[2:0] == 0 ? RES_RESET : FULL_STEPS << r[2:0]);
      chk(setting.steps_rev, xs);
    end
    for (int c = 0; c < 8; c++)
    begin
      sw(4'h1, 3'(c), ~c[0]);
      chk(setting.run_cur, cur_tab[c]);
      chk(setting.hold_cur, c[0] ? cur_tab[c] >> 1 : cur_tab[c]);
    end
    $display("switch table test done");
    sw(4'h0, 3'h0, 1'b1);
    axi_wr(REG_SW_RES, 32'h0001_9001);
    chk(setting.steps_rev, RES_MAX);
    axi_wr(REG_SW_RES, 32'h0000_0064);
    chk(setting.steps_rev, RES_MIN);
    axi_wr(REG_SW_CUR, 32'h0000_0047);
    chk(setting.run_cur, CUR_MAX);
    axi_wr(REG_SW_CUR, 32'h0000_0004);
    chk(setting.run_cur, CUR_MIN);
    axi_wr(REG_SW_RES, 32'h0000_C800);
    axi_wr(REG_SW_CUR, 32'h0000_002D);
    axi_rd(REG_SW_RES);
    chk({rsp, rd}, {RESP_OKAY, 32'h0000_C800});
    sw(4'h5, 3'h5, 1'b1);
    axi_wr(REG_CTRL, 32'h0000_0001);
    chk({setting.steps_rev, setting.run_cur}, {17'h0_C800, 7'h2D});
    axi_wr(REG_CTRL, 32'h0000_0000);
    chk({setting.steps_rev, setting.run_cur}, {17'h0_1900, 7'h36});
    axi_wr(32'h0000_0010, 32'h0000_FFFF);
    chk(rsp, RESP_SLVERR);
    axi_rd(32'h0000_0010);
    chk({rsp, rd}, {RESP_SLVERR, 32'h0000_0000});
    $display("register test done");
    sw(4'h1, 3'h3, 1'b0);
    repeat (IDLE + 20) @(posedge clock);
    chk({idle_reduced, setting.out_cur}, {1'b1, 7'h14});
    steps(3, 1'b1, 1'b0);
    chk({n_ev, n_ev_hi, step_dir}, {32'd3, 32'd3, 1'b1});
    chk({idle_reduced, setting.out_cur}, {1'b0, 7'h28});
    repeat (IDLE - 600) @(posedge clock);
    chk(idle_reduced, 1'b0);
    repeat (500) @(posedge clock);
    chk({idle_reduced, setting.out_cur}, {1'b1, 7'h14});
    sw(4'h1, 3'h3, 1'b1);
    chk(setting.out_cur, 7'h18);
    axi_rd(REG_STATUS);
    chk({rsp, rd}, {RESP_OKAY, 32'h3980_0190});
    $display("idle test done");
    axi_wr(REG_CTRL, 32'h0000_0004);
    steps(2, 1'b0, 1'b0);
    chk({n_ev, n_ev_hi, step_dir}, {32'd2, 32'd0, 1'b0});
    axi_wr(REG_CTRL, 32'h0000_0002);
    steps(2, 1'b1, 1'b1);
    chk({n_ev, ev_dir}, {32'd2, 1'b1});
    steps(2, 1'b0, 1'b1);
    chk({n_ev, ev_dir}, {32'd2, 1'b0});
    $display("pulse mode test done");
    axi_wr(REG_CTRL, 32'h0000_0000);
    drive_allow <= 1'b0;
    repeat (8) @(posedge clock);
    chk(drive_on, 1'b0);
    steps(2, 1'b1, 1'b0);
    chk(n_ev, 0);
    axi_wr(REG_CTRL, 32'h0000_0008);
    chk(drive_on, 1'b1);
    drive_allow <= 1'b1;
    repeat (8) @(posedge clock);
    chk(drive_on, 1'b0);
    $display("drive allow test done");
    print_verdict();
  end
endmodule // testbench
